/* design/adc_pin_config.sv */
/*
 * Analog input pin configuration: channel select, analog/digital split and
 * port direction registers, with the per-pin analog enable they produce.
 * Assumes the CPU bus is synchronous to SYS_CLK and that the converter core
 * reports its busy and enable state as plain levels.
 * Assumes software keeps the split below ten and the channel code below nine;
 * larger values are not blocked, they only turn pins digital or the channel off.
 * Every output is a flop, so pin and channel changes show one edge after the
 * register write that causes them.
 * Software should set a pin to input before selecting it, since a pin left
 * in output mode never reports its channel as usable.
 */
`timescale 1ns/1ps

module adc_pin_config #(
    parameter logic [15:0] P8DIR_ADDR = adc_pin_pkg::ADDR_P8DIR_DEF
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire adc_pin_pkg::cpu_req_s CPU_REQ,
    output adc_pin_pkg::cpu_rsp_s CPU_RSP,
    input wire logic CONV_BUSY,
    input wire logic CONV_ENABLE,
    output logic [3:0] CHANNEL,
    output logic CHANNEL_OK,
    output logic CONV_ABORT,
    output logic CONV_RESTART,
    output logic [adc_pin_pkg::NUM_PINS-1:0] ANALOG_EN,
    output logic [adc_pin_pkg::NUM_PINS-1:0] DIGITAL_SEL,
    output logic [adc_pin_pkg::NUM_PINS-1:0] PIN_OE
);
    import adc_pin_pkg::*;

    // Architectural registers and their next values
    logic [7:0] chsel_reg;
    logic [7:0] chsel_next;
    logic [7:0] split_reg;
    logic [7:0] split_next;
    logic [7:0] p8dir_reg;
    logic [7:0] p8dir_next;
    logic [7:0] p9dir_reg;
    logic [7:0] p9dir_next;

    // Address decode and qualified write strobes
    logic hit_chsel;
    logic hit_split;
    logic hit_p8dir;
    logic hit_p9dir;
    logic wr_chsel;
    logic wr_split;
    logic wr_p8dir;
    logic wr_p9dir;
    logic wr_slow;

    // Per-bit write lanes shared by all four registers
    logic [7:0] lane_en;
    logic [7:0] lane_val;

    // Pin and channel derivations
    logic [NUM_PINS-1:0] dir_in;
    logic [NUM_PINS-1:0] analog_next;
    logic [NUM_PINS-1:0] digital_next;
    logic [(1 << FIELD_W)-1:0] analog_wide;
    logic [FIELD_W-1:0] channel_next;
    logic channel_ok_next;
    logic abort_next;
    logic restart_next;

    // Bus answer
    logic [7:0] rd_next;
    cpu_rsp_s rsp_next;
    cpu_rsp_s rsp_reg;

    // Address decode; the whole address compares, no partial decode
    assign hit_chsel = CPU_REQ.addr == ADDR_CHSEL;
    assign hit_split = CPU_REQ.addr == ADDR_SPLIT;
    assign hit_p8dir = CPU_REQ.addr == P8DIR_ADDR;
    assign hit_p9dir = CPU_REQ.addr == ADDR_P9DIR;

    // Write strobes; a read never disturbs a register
    assign wr_chsel = CPU_REQ.wr && hit_chsel;
    assign wr_split = CPU_REQ.wr && hit_split;
    assign wr_p8dir = CPU_REQ.wr && hit_p8dir;
    assign wr_p9dir = CPU_REQ.wr && hit_p9dir;
    assign wr_slow = wr_chsel || wr_split;

    // Write lanes: byte write opens all eight, bit write only one
    generate
        for (genvar b = 0; b < $bits(lane_en); b++) begin : g_lane
            assign lane_en[b] = !CPU_REQ.bit_op || (CPU_REQ.bit_idx == 3'(b));
            assign lane_val[b] = CPU_REQ.bit_op ? CPU_REQ.wdata[0] : CPU_REQ.wdata[b];
        end
    endgenerate

    // Channel select next; bits 7:4 forced zero so a stray
    // write cannot leave a code the core would misread
    always_comb begin
        chsel_next = chsel_reg;
        if (wr_chsel) begin
            chsel_next = ((chsel_reg & ~lane_en) | (lane_val & lane_en)) & CHSEL_MASK;
        end
    end

    // Channel select flop
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            chsel_reg <= CHSEL_RST;
        end else begin
            chsel_reg <= chsel_next;
        end
    end

    // Split next; bits 7:4 always zero, values above nine
    // are kept as written rather than clamped
    always_comb begin
        split_next = split_reg;
        if (wr_split) begin
            split_next = ((split_reg & ~lane_en) | (lane_val & lane_en)) & SPLIT_MASK;
        end
    end

    // Split flop, all pins analog after reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            split_reg <= SPLIT_RST;
        end else begin
            split_reg <= split_next;
        end
    end

    // Port 8 direction next; all eight bits are real,
    // so a bit write touches only its own pin
    always_comb begin
        p8dir_next = p8dir_reg;
        if (wr_p8dir) begin
            p8dir_next = (p8dir_reg & ~lane_en) | (lane_val & lane_en);
        end
    end

    // Port 8 direction flop, all inputs after reset
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            p8dir_reg <= P8DIR_RST;
        end else begin
            p8dir_reg <= p8dir_next;
        end
    end

    // Port 9 direction next; only bit 0 exists, the rest
    // read one so software sees them as inputs
    always_comb begin
        p9dir_next = p9dir_reg;
        if (wr_p9dir) begin
            p9dir_next = ((p9dir_reg & ~lane_en) | (lane_val & lane_en)) | ~P9DIR_MASK;
        end
    end

    // Port 9 direction flop
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            p9dir_reg <= P9DIR_RST;
        end else begin
            p9dir_reg <= p9dir_next;
        end
    end

    // Direction of all nine pins; the ninth sits in its own register
    assign dir_in = {p9dir_reg[P9DIR_BIT], p8dir_reg};

    // Per-pin split and analog gating; split values above nine are
    // software's fault and simply turn every pin digital
    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
            assign digital_next[i] = split_reg[FIELD_W-1:0] > 4'(i);
            assign analog_next[i] = !digital_next[i] && dir_in[i];
        end
    endgenerate

    // Zero-extended so every four-bit channel code indexes a real
    // bit; codes with no pin behind them read as not analog
    always_comb begin
        analog_wide = '0;
        analog_wide[NUM_PINS-1:0] = analog_next;
    end

    // Channel decode; codes above eight never reach a pin
    assign channel_next = chsel_reg[FIELD_W-1:0];
    assign channel_ok_next = (channel_next <= CH_MAX) && analog_wide[channel_next];

    // Select write mid-conversion aborts; restart only while enabled
    assign abort_next = wr_chsel && CONV_BUSY;
    assign restart_next = abort_next && CONV_ENABLE;

    // Analog enable per pin
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ANALOG_EN <= '0;
        end else begin
            ANALOG_EN <= analog_next;
        end
    end

    // Digital selection per pin
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DIGITAL_SEL <= '0;
        end else begin
            DIGITAL_SEL <= digital_next;
        end
    end

    // Output buffer enable, high while the pin is driven;
    // the inverse of the direction bit
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PIN_OE <= '0;
        end else begin
            PIN_OE <= ~dir_in;
        end
    end

    // Channel index to the core
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CHANNEL <= '0;
        end else begin
            CHANNEL <= channel_next;
        end
    end

    // Channel usable only while its pin is analog and an input,
    // so an output-mode pin never feeds the converter
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CHANNEL_OK <= 1'b0;
        end else begin
            CHANNEL_OK <= channel_ok_next;
        end
    end

    // Abort pulse to the core
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CONV_ABORT <= 1'b0;
        end else begin
            CONV_ABORT <= abort_next;
        end
    end

    // Restart pulse to the core
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            CONV_RESTART <= 1'b0;
        end else begin
            CONV_RESTART <= restart_next;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_next = RD_IDLE;
        if (hit_chsel) begin
            rd_next = chsel_reg;
        end else if (hit_split) begin
            rd_next = split_reg;
        end else if (hit_p8dir) begin
            rd_next = p8dir_reg;
        end else if (hit_p9dir) begin
            rd_next = p9dir_reg;
        end
    end

    // Next bus answer; read data held idle without a read so
    // stale register values never sit on the bus
    always_comb begin
        rsp_next = '0;
        rsp_next.rvalid = CPU_REQ.rd;
        rsp_next.rdata = CPU_REQ.rd ? rd_next : RD_IDLE;
        rsp_next.wait_cyc = wr_slow;
    end

    // Bus answer flop
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    assign CPU_RSP = rsp_reg;

endmodule

/* design/adc_pin_pkg.sv */
/*
 * Constants and carrier types for the analog input pin configuration block.
 * Assumes an 8-bit CPU data bus with a 16-bit address and bit or byte writes.
 */
package adc_pin_pkg;

    // Register addresses
    localparam logic [15:0] ADDR_SPLIT = 16'hFF22;
    localparam logic [15:0] ADDR_CHSEL = 16'hFF2B;
    localparam logic [15:0] ADDR_P9DIR = 16'hFF29;
    localparam logic [15:0] ADDR_P8DIR_DEF = 16'hFF28;

    // Reset values
    localparam logic [7:0] SPLIT_RST = 8'h00;
    localparam logic [7:0] CHSEL_RST = 8'h00;
    localparam logic [7:0] P8DIR_RST = 8'hFF;
    localparam logic [7:0] P9DIR_RST = 8'hFF;

    // Field layouts
    localparam logic [7:0] SPLIT_MASK = 8'h0F;
    localparam logic [7:0] CHSEL_MASK = 8'h0F;
    localparam logic [7:0] P9DIR_MASK = 8'h01;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // Field positions
    localparam int FIELD_W = 4;
    localparam int P9DIR_BIT = 0;

    // Pin counts and limits
    localparam int NUM_PINS = 9;
    localparam int P8_PINS = 8;
    localparam logic [3:0] SPLIT_MAX = 4'h9;
    localparam logic [3:0] CH_MAX = 4'h8;

    // One CPU access: byte write, bit write or read
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_idx;
        logic [7:0] wdata;
    } cpu_req_s;

    // Bus answer
    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic wait_cyc;
    } cpu_rsp_s;

endpackage

/* test/adc_core_model.sv */
/* Converter core stand-in: busy counter per conversion.
   Assumes abort and restart pulses from the pin block. */
`timescale 1ns/1ps
module adc_core_model #(parameter int LEN = 8) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic RUN,
    input wire logic CONV_ABORT,
    input wire logic CONV_RESTART,
    output logic CONV_BUSY,
    output logic CONV_ENABLE
);
    logic [7:0] cnt_reg;
    // Restart wins over abort, so a reselect never stalls
    always_ff @(posedge SYS_CLK) begin
        if (RST)
            cnt_reg <= 8'h00;
        else if (CONV_RESTART || (RUN && cnt_reg == 8'h00))
            cnt_reg <= 8'(LEN);
        else if (CONV_ABORT)
            cnt_reg <= 8'h00;
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end
    assign CONV_BUSY = cnt_reg != 8'h00;
    assign CONV_ENABLE = RUN;
endmodule

/* test/adc_pin_config_properties.sv */
/* Port assertions for the pin configuration block.
   Bound to every adc_pin_config instance. */
`timescale 1ns/1ps
module adc_pin_config_properties (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire adc_pin_pkg::cpu_req_s CPU_REQ,
    input wire adc_pin_pkg::cpu_rsp_s CPU_RSP,
    input wire logic CONV_BUSY,
    input wire logic CONV_ENABLE,
    input wire logic [3:0] CHANNEL,
    input wire logic CHANNEL_OK,
    input wire logic CONV_ABORT,
    input wire logic CONV_RESTART,
    input wire logic [8:0] ANALOG_EN,
    input wire logic [8:0] DIGITAL_SEL,
    input wire logic [8:0] PIN_OE
);
    import adc_pin_pkg::*;
    logic sel_wr;
    logic spl_wr;
    // Decoded register writes
    assign sel_wr = CPU_REQ.wr && CPU_REQ.addr == ADDR_CHSEL;
    assign spl_wr = CPU_REQ.wr && CPU_REQ.addr == ADDR_SPLIT;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_wait_on_write: assert property ((sel_wr || spl_wr) |=> CPU_RSP.wait_cyc)
        else $error("wait cycle missing");
    a_read_answer: assert property (CPU_REQ.rd |=> CPU_RSP.rvalid)
        else $error("read not answered");
    a_abort_busy: assert property (sel_wr && CONV_BUSY |=> CONV_ABORT)
        else $error("abort missing");
    a_restart_enabled: assert property (sel_wr && CONV_BUSY && CONV_ENABLE |=> CONV_RESTART)
        else $error("restart missing");
    a_channel_follows: assert property (sel_wr && !CPU_REQ.bit_op ##1 !CPU_REQ.wr
        |=> CHANNEL == $past(CPU_REQ.wdata[3:0], 2)) else $error("channel wrong");
    a_split_digital: assert property (spl_wr && !CPU_REQ.bit_op && CPU_REQ.wdata[3:0] <= 4'h9 ##1 !CPU_REQ.wr
        |=> DIGITAL_SEL == 9'((10'h001 << $past(CPU_REQ.wdata[3:0], 2)) - 10'h001)) else $error("split wrong");
    a_channel_range: assert property (CHANNEL > CH_MAX |-> !CHANNEL_OK)
        else $error("bad channel accepted");
    a_analog_input: assert property (!$past(RST) |-> ANALOG_EN == (~DIGITAL_SEL & ~PIN_OE))
        else $error("analog enable wrong");
    c_restart: cover property (CONV_RESTART);
    c_wait: cover property (CPU_RSP.wait_cyc);
    c_ninth: cover property (CHANNEL_OK && CHANNEL == CH_MAX);
endmodule
bind adc_pin_config adc_pin_config_properties adc_pin_config_properties_i (.*);

/* test/testbench.sv */
/* Self-checking bench for the pin configuration block.
   Drives the CPU bus; a core model answers the converter link. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("MISMATCH %s exp %h got %h", n, e, g); \
    end \
end
module testbench;
    import adc_pin_pkg::*;
    logic SYS_CLK, RST, RUN, busy, en, abt, rst_c, ok;
    cpu_req_s req;
    cpu_rsp_s rsp;
    logic [3:0] ch;
    logic [8:0] ana, dig, oe;
    int n_errors = 0;
    int n_tests = 0;
    int k;
    adc_pin_config adc_pin_config_i (.SYS_CLK(SYS_CLK), .RST(RST), .CPU_REQ(req), .CPU_RSP(rsp),
        .CONV_BUSY(busy), .CONV_ENABLE(en), .CHANNEL(ch), .CHANNEL_OK(ok), .CONV_ABORT(abt),
        .CONV_RESTART(rst_c), .ANALOG_EN(ana), .DIGITAL_SEL(dig), .PIN_OE(oe));
    adc_core_model adc_core_model_i (.SYS_CLK(SYS_CLK), .RST(RST), .RUN(RUN), .CONV_ABORT(abt),
        .CONV_RESTART(rst_c), .CONV_BUSY(busy), .CONV_ENABLE(en));
    initial begin
        SYS_CLK = 1'h0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    // One access: launch, hold one edge, release, settle
    task acc(input logic [15:0] a, input logic w, input logic b, input logic [7:0] d);
        @(posedge SYS_CLK) req <= {a, w, ~w, b, 3'h0, d};
        @(posedge SYS_CLK) req <= '0;
        #1;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        acc(a, 1'h1, 1'h0, d);
        `CHK("wait", a == ADDR_CHSEL || a == ADDR_SPLIT, rsp.wait_cyc)
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        acc(a, 1'h0, 1'h0, 8'h00);
        `CHK("rdata", {1'h1, e}, {rsp.rvalid, rsp.rdata})
    endtask
    task summarize;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog well past the expected run
    initial begin
        repeat (3000) @(posedge SYS_CLK);
        n_errors++;
        summarize;
    end
    initial begin
        RST = 1'h1;
        RUN = 1'h0;
        req = '0;
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'h0;
        rd(ADDR_SPLIT, 8'h00);
        rd(ADDR_CHSEL, 8'h00);
        rd(ADDR_P8DIR_DEF, 8'hFF);
        rd(ADDR_P9DIR, 8'hFF);
        rd(16'hFF30, 8'h00);
        for (k = 0; k < 10; k++) begin
            wr(ADDR_SPLIT, 8'(k));
            @(posedge SYS_CLK) #1;
            `CHK("digital", 9'((10'h001 << k) - 10'h001), dig)
            `CHK("analog", ~9'((10'h001 << k) - 10'h001), ana)
        end
        rd(ADDR_SPLIT, 8'h09);
        wr(ADDR_SPLIT, 8'h00);
        wr(ADDR_P8DIR_DEF, 8'h0F);
        acc(ADDR_P9DIR, 1'h1, 1'h1, 8'h00);
        wr(ADDR_CHSEL, 8'h05);
        @(posedge SYS_CLK) #1;
        `CHK("oe", 9'h1F0, oe)
        `CHK("analog", 9'h00F, ana)
        `CHK("ok", 1'h0, ok)
        rd(ADDR_P9DIR, 8'hFE);
        wr(ADDR_P9DIR, 8'hFF);
        wr(ADDR_CHSEL, 8'h08);
        @(posedge SYS_CLK) #1;
        `CHK("channel", 5'h18, {ok, ch})
        wr(ADDR_CHSEL, 8'h0F);
        @(posedge SYS_CLK) #1;
        `CHK("channel", 5'h0F, {ok, ch})
        @(posedge SYS_CLK) RUN <= 1'h1;
        k = 0;
        while (busy !== 1'h1 && k < 50) begin
            @(posedge SYS_CLK) #1;
            k++;
        end
        wr(ADDR_CHSEL, 8'h00);
        `CHK("abort", 2'h3, {abt, rst_c})
        @(posedge SYS_CLK) RUN <= 1'h0;
        wr(ADDR_CHSEL, 8'h01);
        `CHK("abort", 2'h2, {abt, rst_c})
        summarize;
    end
endmodule
